// *** hw/cotb_fuse_loader.sv ***
// fuse loader: walks the six trim slots, fetches each default word from the
// nonvolatile fuse store and hands it to the register bank as a write pulse.
// assumes the fuse store answers each held request with a one-cycle ack.
`timescale 1ns/1ps
`default_nettype none

module cotb_fuse_loader
    import cotb_pkg::*;
(
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        start_i,
    input  wire cotb_pkg::cotb_fuse_rsp_type fuse_rsp_i,
    output var  cotb_pkg::cotb_fuse_req_type fuse_req_o,
    output logic                             wr_valid_o,
    output cotb_pkg::cotb_slot_type          wr_slot_o,
    output logic [15:0]                      wr_data_o,
    output logic                             busy_o
);
    import cotb_pkg::*;

    typedef enum logic [1:0] {
        LD_IDLE = 2'b00,
        LD_REQ  = 2'b01
    } cotb_ld_state_type;

    cotb_ld_state_type state_q;
    cotb_slot_type     slot_q;

    // reset starts a load at once, so the bank never serves stale defaults
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= LD_REQ;
            slot_q  <= SLOT_CORE1;
        end else begin
            unique case (state_q)
                LD_IDLE: begin
                    if (start_i) begin
                        state_q <= LD_REQ;
                        slot_q  <= SLOT_CORE1;
                    end
                end
                LD_REQ: begin
                    if (fuse_rsp_i.ack) begin
                        if (slot_q == SLOT_CORE4) begin
                            state_q <= LD_IDLE;
                        end else begin
                            slot_q <= cotb_slot_type'(slot_q + 3'h1);
                        end
                    end
                end
                default: state_q <= LD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_valid_o <= 1'b0;
            wr_slot_o  <= SLOT_CORE1;
            wr_data_o  <= TRIM_RESET;
        end else begin
            wr_valid_o <= (state_q == LD_REQ) && fuse_rsp_i.ack;
            if ((state_q == LD_REQ) && fuse_rsp_i.ack) begin
                wr_slot_o <= slot_q;
                wr_data_o <= fuse_rsp_i.dat;
            end
        end
    end

    assign fuse_req_o.req = (state_q == LD_REQ);
    assign fuse_req_o.idx = slot_q;
    assign busy_o         = (state_q != LD_IDLE) || wr_valid_o;

endmodule : cotb_fuse_loader

`default_nettype wire

// *** hw/cotb_pkg.sv ***
// package for the converter offset trim bank: register map, field layout,
// reset values, slot codes and the carrier structs of the bus and fuse port.
// assumes a 32-bit classic wishbone slave port and one register clock.
package cotb_pkg;

    localparam int unsigned NUM_TRIM      = 6;
    localparam int unsigned IDX_W         = 10;

    // printed offsets are register indices; byte address is four times the index
    localparam logic [9:0]  IDX_CORE1     = 10'h332;
    localparam logic [9:0]  IDX_CORE2_A   = 10'h334;
    localparam logic [9:0]  IDX_CORE2_B   = 10'h336;
    localparam logic [9:0]  IDX_CORE3_C   = 10'h338;
    localparam logic [9:0]  IDX_CORE3_D   = 10'h33a;
    localparam logic [9:0]  IDX_CORE4     = 10'h33c;
    localparam logic [9:0]  IDX_STATUS    = 10'h340;
    localparam logic [9:0]  IDX_CONTROL   = 10'h341;

    localparam int unsigned TRIM_MSB      = 11;
    localparam int unsigned RSVD_LSB      = 12;
    localparam int unsigned RSVD_MSB      = 15;
    localparam logic [15:0] TRIM_RESET    = 16'h0000;
    localparam logic [3:0]  RSVD_DEFAULT  = 4'h0;

    localparam int unsigned STATUS_DONE_BIT    = 0;
    localparam int unsigned STATUS_BUSY_BIT    = 1;
    localparam int unsigned CONTROL_RELOAD_BIT = 0;

    typedef enum logic [2:0] {
        SLOT_CORE1   = 3'b000,
        SLOT_CORE2_A = 3'b001,
        SLOT_CORE2_B = 3'b010,
        SLOT_CORE3_C = 3'b011,
        SLOT_CORE3_D = 3'b100,
        SLOT_CORE4   = 3'b101
    } cotb_slot_type;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [15:0] adr;
        logic [31:0] dat;
    } cotb_wb_req_type;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } cotb_wb_rsp_type;

    typedef struct packed {
        logic          req;
        cotb_slot_type idx;
    } cotb_fuse_req_type;

    typedef struct packed {
        logic        ack;
        logic [15:0] dat;
    } cotb_fuse_rsp_type;

endpackage : cotb_pkg

// *** hw/cotb_trim_bank.sv ***
// converter offset trim bank: six 16-bit trim registers behind a classic
// wishbone slave, loaded from the fuse store after reset, steering the
// offset trim of four converter cores.
// assumes one register clock, synchronous reset and a 32-bit wishbone master.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module cotb_trim_bank
    import cotb_pkg::*;
(
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire cotb_pkg::cotb_wb_req_type   wb_req_i,
    output var  cotb_pkg::cotb_wb_rsp_type   wb_rsp_o,
    input  wire cotb_pkg::cotb_fuse_rsp_type fuse_rsp_i,
    output var  cotb_pkg::cotb_fuse_req_type fuse_req_o,
    input  wire logic                        core2_input_b_sel_i,
    input  wire logic                        core3_input_d_sel_i,
    output logic [11:0]                      core1_trim_o,
    output logic [11:0]                      core2_trim_o,
    output logic [11:0]                      core3_trim_o,
    output logic [11:0]                      core4_trim_o
);
    import cotb_pkg::*;

    logic [15:0]   regs_q [NUM_TRIM];
    logic          ack_q;
    logic [31:0]   rdat_q;
    logic          reload_q;
    logic          ld_valid;
    cotb_slot_type ld_slot;
    logic [15:0]   ld_data;
    logic          ld_busy;
    logic          req_live;
    logic          bus_take;
    logic          bus_wr;
    logic [9:0]    req_idx;
    logic [3:0]    slot_map;
    logic          req_in_map;
    logic          hit_trim;
    cotb_slot_type hit_slot;

    // maps a register index onto a trim slot; top bit of the result flags a hit
    function automatic logic [3:0] slot_of(input logic [9:0] idx);
        logic [3:0] r;
        r = 4'h0;
        unique case (idx)
            IDX_CORE1:   r = {1'b1, SLOT_CORE1};
            IDX_CORE2_A: r = {1'b1, SLOT_CORE2_A};
            IDX_CORE2_B: r = {1'b1, SLOT_CORE2_B};
            IDX_CORE3_C: r = {1'b1, SLOT_CORE3_C};
            IDX_CORE3_D: r = {1'b1, SLOT_CORE3_D};
            IDX_CORE4:   r = {1'b1, SLOT_CORE4};
            default:     r = 4'h0;
        endcase
        return r;
    endfunction : slot_of

    // byte-lane merge of a 16-bit register with a write word
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wdat,
                                            input logic [3:0]  sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = wdat[7:0];
        end
        if (sel[1]) begin
            r[15:8] = wdat[15:8];
        end
        return r;
    endfunction : merge16

    cotb_fuse_loader u_loader (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .start_i    (reload_q),
        .fuse_rsp_i (fuse_rsp_i),
        .fuse_req_o (fuse_req_o),
        .wr_valid_o (ld_valid),
        .wr_slot_o  (ld_slot),
        .wr_data_o  (ld_data),
        .busy_o     (ld_busy)
    );

    // bus decode; the upper address bits above the index must be zero
    assign req_live   = wb_req_i.cyc && wb_req_i.stb;
    assign req_idx    = wb_req_i.adr[11:2];
    assign req_in_map = (wb_req_i.adr[15:12] == 4'h0);
    assign slot_map   = slot_of(req_idx);
    assign hit_trim   = req_in_map && slot_map[3];
    assign hit_slot   = cotb_slot_type'(slot_map[2:0]);

    // the bus is held off while defaults stream in, so software cannot race
    // the loader; a stalled cycle simply sees ack arrive later
    assign bus_take = req_live && !ack_q && !ld_busy;
    assign bus_wr   = req_live && ack_q && wb_req_i.we;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_take;
        end
    end

    // read data is captured when ack is raised and stands while ack is high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= 32'h0000_0000;
        end else if (bus_take) begin
            rdat_q <= 32'h0000_0000;
            if (hit_trim) begin
                rdat_q[15:0] <= regs_q[hit_slot];
            end else if (req_in_map && (req_idx == IDX_STATUS)) begin
                rdat_q[STATUS_DONE_BIT] <= !ld_busy;
                rdat_q[STATUS_BUSY_BIT] <= ld_busy;
            end
        end
    end

    assign wb_rsp_o.ack = ack_q;
    assign wb_rsp_o.dat = rdat_q;

    // a write lands on the edge where the master samples ack; reserved bits
    // are stored as written since the host keeps them at zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_TRIM; i++) begin
                regs_q[i] <= TRIM_RESET;
            end
        end else if (ld_valid) begin
            regs_q[ld_slot] <= ld_data;
        end else if (bus_wr && hit_trim) begin
            regs_q[hit_slot] <= merge16(regs_q[hit_slot], wb_req_i.dat, wb_req_i.sel);
        end
    end

    // reload pulse from the control register restarts the fuse walk
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reload_q <= 1'b0;
        end else begin
            reload_q <= bus_wr && req_in_map && (req_idx == IDX_CONTROL)
                        && wb_req_i.sel[0] && wb_req_i.dat[CONTROL_RELOAD_BIT];
        end
    end

    // trim outputs are registered so a select change retargets cleanly
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core1_trim_o <= TRIM_RESET[TRIM_MSB:0];
            core2_trim_o <= TRIM_RESET[TRIM_MSB:0];
            core3_trim_o <= TRIM_RESET[TRIM_MSB:0];
            core4_trim_o <= TRIM_RESET[TRIM_MSB:0];
        end else begin
            core1_trim_o <= regs_q[SLOT_CORE1][TRIM_MSB:0];
            core2_trim_o <= core2_input_b_sel_i
                          ? regs_q[SLOT_CORE2_B][TRIM_MSB:0]
                          : regs_q[SLOT_CORE2_A][TRIM_MSB:0];
            core3_trim_o <= core3_input_d_sel_i
                          ? regs_q[SLOT_CORE3_D][TRIM_MSB:0]
                          : regs_q[SLOT_CORE3_C][TRIM_MSB:0];
            core4_trim_o <= regs_q[SLOT_CORE4][TRIM_MSB:0];
        end
    end

    a_core1_trim_out:
    assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> core1_trim_o == $past(regs_q[SLOT_CORE1][TRIM_MSB:0]))
        else $error("core1 trim does not follow its register");

    a_core2_input_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
        (!core2_input_b_sel_i && !rst_i) |=> core2_trim_o == $past(regs_q[SLOT_CORE2_A][TRIM_MSB:0]))
        else $error("core2 input A trim not applied");

    a_core2_input_b:
    assert property (@(posedge clk_i) disable iff (rst_i)
        core2_input_b_sel_i |=> core2_trim_o == $past(regs_q[SLOT_CORE2_B][TRIM_MSB:0]))
        else $error("core2 input B trim not applied");

    a_core3_input_c:
    assert property (@(posedge clk_i) disable iff (rst_i)
        !core3_input_d_sel_i |=> core3_trim_o == $past(regs_q[SLOT_CORE3_C][TRIM_MSB:0]))
        else $error("core3 input C trim not applied");

    a_core3_input_d:
    assert property (@(posedge clk_i) disable iff (rst_i)
        core3_input_d_sel_i |=> core3_trim_o == $past(regs_q[SLOT_CORE3_D][TRIM_MSB:0]))
        else $error("core3 input D trim not applied");

    a_core4_reset_zero:
    assert property (@(posedge clk_i)
        rst_i |=> regs_q[SLOT_CORE4] == TRIM_RESET && core4_trim_o == 12'h000)
        else $error("core4 trim not zero after reset");

    a_fuse_default_load:
    assert property (@(posedge clk_i) disable iff (rst_i)
        ld_valid |=> regs_q[$past(ld_slot)] == $past(ld_data))
        else $error("fuse default not stored in trim register");

    a_fuse_walk_done:
    assert property (@(posedge clk_i) disable iff (rst_i)
        (fuse_req_o.req && fuse_req_o.idx == SLOT_CORE4 && fuse_rsp_i.ack) |-> ##2 !ld_busy)
        else $error("loader still busy after last fuse word");

    a_read_zero_ext:
    assert property (@(posedge clk_i) disable iff (rst_i)
        (ack_q && !wb_req_i.we) |-> wb_rsp_o.dat[31:16] == 16'h0000)
        else $error("trim read not zero extended");

    a_ack_one_cycle:
    assert property (@(posedge clk_i) disable iff (rst_i)
        ack_q |=> !ack_q)
        else $error("ack held for more than one cycle");

    a_no_ack_loading:
    assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(ack_q) |-> !$past(ld_busy))
        else $error("bus answered while defaults were loading");

    a_core1_address:
    assert property (@(posedge clk_i) disable iff (rst_i)
        (req_in_map && req_idx == IDX_CORE1) |-> hit_trim && hit_slot == SLOT_CORE1)
        else $error("core1 trim index does not reach its slot");

    a_core4_address:
    assert property (@(posedge clk_i) disable iff (rst_i)
        (req_in_map && req_idx == IDX_CORE4) |-> hit_trim && hit_slot == SLOT_CORE4)
        else $error("core4 trim index does not reach its own slot");

    a_core4_trim_out:
    assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> core4_trim_o == $past(regs_q[SLOT_CORE4][TRIM_MSB:0]))
        else $error("core4 trim does not follow its register");

    a_regs_reset_zero:
    assert property (@(posedge clk_i)
        rst_i |=> regs_q[SLOT_CORE1] == TRIM_RESET && regs_q[SLOT_CORE2_A] == TRIM_RESET
                  && regs_q[SLOT_CORE2_B] == TRIM_RESET && regs_q[SLOT_CORE3_C] == TRIM_RESET
                  && regs_q[SLOT_CORE3_D] == TRIM_RESET)
        else $error("trim register not zero after reset");

    a_trims_reset_zero:
    assert property (@(posedge clk_i)
        rst_i |=> core1_trim_o == 12'h000 && core2_trim_o == 12'h000 && core3_trim_o == 12'h000)
        else $error("core trim output not zero after reset");

    a_bus_reset_idle:
    assert property (@(posedge clk_i)
        rst_i |=> !wb_rsp_o.ack && wb_rsp_o.dat == 32'h0000_0000)
        else $error("bus response not idle after reset");

    a_ack_follows_take:
    assert property (@(posedge clk_i) disable iff (rst_i)
        (req_live && !ack_q && !ld_busy) |=> wb_rsp_o.ack)
        else $error("request taken but not acknowledged");

    a_bus_held_load:
    assert property (@(posedge clk_i) disable iff (rst_i)
        (req_live && ld_busy) |=> !wb_rsp_o.ack)
        else $error("request acknowledged while defaults were loading");

    a_load_over_bus:
    assert property (@(posedge clk_i) disable iff (rst_i)
        ld_valid |-> !bus_wr)
        else $error("bus write met a fuse default write");

    a_lane0_write:
    assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_wr && hit_trim && !ld_valid && wb_req_i.sel[0])
        |=> regs_q[$past(hit_slot)][7:0] == $past(wb_req_i.dat[7:0]))
        else $error("low byte lane write lost");

    a_lane0_keep:
    assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_wr && hit_trim && !ld_valid && !wb_req_i.sel[0])
        |=> regs_q[$past(hit_slot)][7:0] == $past(regs_q[hit_slot][7:0]))
        else $error("unselected low byte lane changed");

    a_lane1_write:
    assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_wr && hit_trim && !ld_valid && wb_req_i.sel[1])
        |=> regs_q[$past(hit_slot)][15:8] == $past(wb_req_i.dat[15:8]))
        else $error("high byte lane write lost");

    a_lane1_keep:
    assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_wr && hit_trim && !ld_valid && !wb_req_i.sel[1])
        |=> regs_q[$past(hit_slot)][15:8] == $past(regs_q[hit_slot][15:8]))
        else $error("unselected high byte lane changed");

    a_unmapped_keep:
    assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_wr && !hit_trim && !ld_valid)
        |=> $stable(regs_q[SLOT_CORE1]) && $stable(regs_q[SLOT_CORE4]))
        else $error("write outside the trim map changed a register");

    a_trim_read_back:
    assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_take && hit_trim) |=> wb_rsp_o.dat == {16'h0000, $past(regs_q[hit_slot])})
        else $error("trim read does not return the register unchanged");

    a_unmapped_read_zero:
    assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_take && !hit_trim && !(req_in_map && req_idx == IDX_STATUS))
        |=> wb_rsp_o.dat == 32'h0000_0000)
        else $error("read outside the trim map not zero");

    a_status_read_done:
    assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_take && req_in_map && req_idx == IDX_STATUS) |=> wb_rsp_o.dat == 32'h0000_0001)
        else $error("status read does not show the load as done");

    a_reload_starts:
    assert property (@(posedge clk_i) disable iff (rst_i)
        reload_q |=> fuse_req_o.req && fuse_req_o.idx == SLOT_CORE1)
        else $error("reload did not restart the fuse walk at core1");

    a_fuse_req_hold:
    assert property (@(posedge clk_i) disable iff (rst_i)
        (fuse_req_o.req && !fuse_rsp_i.ack) |=> fuse_req_o.req && $stable(fuse_req_o.idx))
        else $error("fuse request dropped or moved before its answer");

    a_fuse_slot_step:
    assert property (@(posedge clk_i) disable iff (rst_i)
        (fuse_req_o.req && fuse_rsp_i.ack && fuse_req_o.idx != SLOT_CORE4)
        |=> fuse_req_o.req && fuse_req_o.idx == cotb_slot_type'($past(fuse_req_o.idx) + 3'h1))
        else $error("fuse walk skipped a slot");

    a_fuse_stay_idle:
    assert property (@(posedge clk_i) disable iff (rst_i)
        (!fuse_req_o.req && !reload_q) |=> !fuse_req_o.req)
        else $error("fuse walk started without a reload");

    a_loader_busy:
    assert property (@(posedge clk_i) disable iff (rst_i)
        fuse_req_o.req |-> ld_busy)
        else $error("loader shows idle while fetching defaults");

endmodule : cotb_trim_bank

`default_nettype wire

// *** verification/tb_top.sv ***
// testbench for the converter offset trim bank: drives the wishbone port,
// answers the fuse store and checks register contents and core trim outputs.
// assumes the bank stalls bus requests until the fuse load has finished.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_top;
    import cotb_pkg::*;

    logic              clk_i;
    logic              rst_i;
    logic              b_sel;
    logic              d_sel;
    cotb_wb_req_type   wb_req;
    cotb_wb_rsp_type   wb_rsp;
    cotb_fuse_req_type fuse_req;
    cotb_fuse_rsp_type fuse_rsp = '0;
    logic [11:0]       t1, t2, t3, t4;
    logic [31:0]       rd;
    logic [15:0]       exp_q [6];
    logic [15:0]       adr_tab [6] = '{16'h0cc8, 16'h0cd0, 16'h0cd8, 16'h0ce0, 16'h0ce8, 16'h0cf0};
    // top trim bits set in some words so a signed reading would show
    logic [15:0]       fuse_tab [6] = '{16'h0a5c, 16'h0f01, 16'h0123, 16'h0800, 16'h0fff, 16'h0456};
    int                num_errors = 0;
    int                compares = 0;
    int                cycles = 0;

    cotb_trim_bank i_cotb_trim_bank (
        .clk_i               (clk_i),
        .rst_i               (rst_i),
        .wb_req_i            (wb_req),
        .wb_rsp_o            (wb_rsp),
        .fuse_rsp_i          (fuse_rsp),
        .fuse_req_o          (fuse_req),
        .core2_input_b_sel_i (b_sel),
        .core3_input_d_sel_i (d_sel),
        .core1_trim_o        (t1),
        .core2_trim_o        (t2),
        .core3_trim_o        (t3),
        .core4_trim_o        (t4)
    );

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // fuse store answers each held request one cycle later, ack lasts one cycle
    always @(posedge clk_i) begin
        fuse_rsp.ack <= (fuse_req.req === 1'b1) && !fuse_rsp.ack;
        fuse_rsp.dat <= fuse_tab[fuse_req.idx];
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 5000) begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    // one classic cycle, held until ack; only the global timeout ends the wait
    task automatic wb(input logic we, input logic [15:0] adr, input logic [31:0] dat, input logic [3:0] sel);
        @(posedge clk_i);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: sel, adr: adr, dat: dat};
        do @(posedge clk_i); while (wb_rsp.ack !== 1'b1);
        rd = wb_rsp.dat;
        wb_req <= '0;
    endtask : wb

    task automatic chk_out();
        for (int b = 0; b < 2; b++) begin
            @(posedge clk_i);
            b_sel <= b[0];
            d_sel <= b[0];
            repeat (3) @(posedge clk_i);
            `CHK(t1, exp_q[0][11:0])
            `CHK(t2, exp_q[b ? 2 : 1][11:0])
            `CHK(t3, exp_q[b ? 4 : 3][11:0])
            `CHK(t4, exp_q[5][11:0])
        end
    endtask : chk_out

    task automatic chk_regs();
        for (int i = 0; i < 6; i++) begin
            wb(1'b0, adr_tab[i], 32'h0, 4'hf);
            `CHK(rd, {16'h0000, exp_q[i]})
        end
        chk_out();
    endtask : chk_regs

    task automatic t_load();
        wb(1'b0, 16'h0d00, 32'h0, 4'hf);
        `CHK(rd, 32'h0000_0001)
        exp_q = fuse_tab;
        chk_regs();
    endtask : t_load

    task automatic t_write();
        for (int i = 0; i < 6; i++) begin
            exp_q[i] = 16'h0810 + 16'(i) * 16'h0111;
            wb(1'b1, adr_tab[i], {16'h0000, exp_q[i]}, 4'hf);
        end
        chk_regs();
    endtask : t_write

    // lanes 3:2 and unselected lanes must leave the register alone
    task automatic t_lane();
        wb(1'b1, adr_tab[5], 32'hffff_ab77, 4'b0001);
        exp_q[5][7:0] = 8'h77;
        wb(1'b1, adr_tab[2], 32'hffff_0b99, 4'b0010);
        exp_q[2][15:8] = 8'h0b;
        chk_regs();
    endtask : t_lane

    task automatic t_unmapped();
        wb(1'b1, 16'h0cf8, 32'h0000_0555, 4'hf);
        wb(1'b1, 16'h1cc8, 32'h0000_0666, 4'hf);
        wb(1'b0, 16'h0cf8, 32'h0, 4'hf);
        `CHK(rd, 32'h0)
        wb(1'b0, 16'h1cc8, 32'h0, 4'hf);
        `CHK(rd, 32'h0)
        chk_regs();
    endtask : t_unmapped

    task automatic t_reload();
        wb(1'b1, 16'h0d04, 32'h0000_0001, 4'h1);
        exp_q = fuse_tab;
        chk_regs();
        wb(1'b0, 16'h0d00, 32'h0, 4'hf);
        `CHK(rd, 32'h0000_0001)
    endtask : t_reload

    initial begin
        rst_i    = 1'b1;
        b_sel    = 1'b0;
        d_sel    = 1'b0;
        wb_req   = '0;
        repeat (5) @(posedge clk_i);
        `CHK(t4, 12'h000)
        `CHK(wb_rsp.ack, 1'b0)
        rst_i <= 1'b0;
        t_load();
        t_write();
        t_lane();
        t_unmapped();
        t_reload();
        report_and_stop();
    end

endmodule : tb_top

`default_nettype wire
